// ===== logic/dpm_pin_assign.sv
// Debug port pin assignment: routes five shared lines between the debug port and general-purpose control
// ==================================================================================================
// Summary of operation
// - Five debug signals exist as alternate functions of general-purpose lines.
// - Mode select/data on A13, clock on A14, data input on A15.
// - Data output and trace on B3, active-low test reset on B4.
// - Serial-wire data is bidirectional; all JTAG inputs and clock are inputs.
// - Port offers five-line JTAG and two-line serial-wire access to bus port.
// - Serial-wire data shares mode select; serial clock shares test clock.
// - After any reset all five lines belong to the debug port.
// - Trace is off after reset; data-out carries trace only when programmed.
// - Software may reassign debug lines to other functions by register.
// - Full port without test reset releases only B4.
// - Serial-wire only keeps A13 and A14, releases A15, B3, B4.
// - With both ports disabled all five lines are released.
// - Debug-held lines: pull-ups on reset, data-in, mode; pull-down on clock.
// - Test clock line clocks debug flops directly; never left floating.
// - Released lines return to general-purpose control.
// - Released defaults: pulled-up inputs, pulled-down clock, floating data-out.
// - Released lines behave as plain general-purpose I/O, no debug effect.
// ==================================================================================================
//
// Chosen here: the register offsets and strobed register access.
module dpm_pin_assign
(
	input  wire logic                   clk,            // System clock, 20 MHz
	input  wire logic                   reset_n,        // Async reset, active low
	input  wire logic                   tck_clk,        // Test clock from line A14, link domain
	// Register port
	input  wire logic [3:0]             reg_addr,       // Register address
	input  wire logic [7:0]             reg_wdata,      // Write data
	input  wire logic                   reg_wr,         // Write strobe
	input  wire logic                   reg_rd,         // Read strobe
	output logic      [7:0]             reg_rdata,      // Read data, cycle after strobe
	// Pads
	input  wire logic [4:0]             pad_in,         // Pad input levels
	output dpm_pkg::dpm_pad_t           pad_ctl,        // Pad drive, enable and pulls
	// Core debug port, link domain
	input  wire dpm_pkg::dpm_core_t     core_in,        // Debug port outputs
	output logic      [4:0]             core_lines,     // Line levels seen by debug port
	output logic      [4:0]             gpio_in         // Synchronised levels for software
);

	// ==============================================================================
	// Registers
	// ==============================================================================
	dpm_pkg::dpm_mode_t mode_ff;
	logic               trace_en_ff;
	logic [4:0]         gpio_out_ff;
	logic [4:0]         gpio_dir_ff;
	logic [4:0]         gpio_pup_ff;
	logic [4:0]         gpio_pdn_ff;
	logic [4:0]         claim;
	logic [4:0]         nxt_claim;
	dpm_pkg::dpm_pad_t  nxt_pad;

	// Claim mask from mode
	always_comb
	begin
		case (mode_ff)
			dpm_pkg::DPM_FULL:     nxt_claim = dpm_pkg::CLAIM_FULL;
			dpm_pkg::DPM_NO_TRST:  nxt_claim = dpm_pkg::CLAIM_NO_TRST;
			dpm_pkg::DPM_SWD_ONLY: nxt_claim = dpm_pkg::CLAIM_SWD_ONLY;
			default:               nxt_claim = dpm_pkg::CLAIM_NONE;
		endcase
	end
	assign claim = nxt_claim;

	// Configuration writes; reset returns full debug ownership, trace off
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_ff     <= dpm_pkg::DPM_FULL;
			trace_en_ff <= 1'b0;
		end
		else if (reg_wr && reg_addr == dpm_pkg::ADDR_PORT_CFG)
		begin
			mode_ff     <= dpm_pkg::dpm_mode_t'(reg_wdata[dpm_pkg::CFG_MODE_LSB +: 2]);
			trace_en_ff <= reg_wdata[dpm_pkg::CFG_TRACE_BIT];
		end
	end

	// General-purpose control registers, reset to the released-line defaults
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			gpio_out_ff <= dpm_pkg::RST_GPIO_OUT;
			gpio_dir_ff <= dpm_pkg::RST_GPIO_DIR;
			gpio_pup_ff <= dpm_pkg::RST_GPIO_PUP;
			gpio_pdn_ff <= dpm_pkg::RST_GPIO_PDN;
		end
		else if (reg_wr)
		begin
			if (reg_addr == dpm_pkg::ADDR_GPIO_OUT)
				gpio_out_ff <= reg_wdata[4:0];
			else if (reg_addr == dpm_pkg::ADDR_GPIO_DIR)
				gpio_dir_ff <= reg_wdata[4:0];
			else if (reg_addr == dpm_pkg::ADDR_GPIO_PUP)
				gpio_pup_ff <= reg_wdata[4:0];
			else if (reg_addr == dpm_pkg::ADDR_GPIO_PDN)
				gpio_pdn_ff <= reg_wdata[4:0];
		end
	end

	// ==============================================================================
	// Crossing between system and link domains
	// ==============================================================================
	// Claim and trace enable are levels: three flops into the link domain
	// A bit counts only once the second and third flops agree; each bit settles on its own,
	// so core_lines and the debug drive enables can briefly see a mix of old and new mask bits
	logic [5:0] to_lnk_s1_ff;
	logic [5:0] to_lnk_s2_ff;
	logic [5:0] to_lnk_s3_ff;
	logic [5:0] to_lnk_ff;
	always_ff @(posedge tck_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			to_lnk_s1_ff <= {1'b0, dpm_pkg::CLAIM_FULL};
			to_lnk_s2_ff <= {1'b0, dpm_pkg::CLAIM_FULL};
			to_lnk_s3_ff <= {1'b0, dpm_pkg::CLAIM_FULL};
			to_lnk_ff    <= {1'b0, dpm_pkg::CLAIM_FULL};
		end
		else
		begin
			to_lnk_s1_ff <= {trace_en_ff, claim};
			to_lnk_s2_ff <= to_lnk_s1_ff;
			to_lnk_s3_ff <= to_lnk_s2_ff;
			to_lnk_ff    <= (to_lnk_s2_ff & to_lnk_s3_ff) | (to_lnk_ff & (to_lnk_s2_ff | to_lnk_s3_ff));
		end
	end

	// Link-domain view of lines: claimed lines go to the debug port, released ones idle
	// Released lines present safe idle levels so no debug activity leaks through
	logic [4:0] core_lines_ff;
	always_ff @(posedge tck_clk or negedge reset_n)
	begin
		if (!reset_n)
			core_lines_ff <= dpm_pkg::DBG_PUP;
		else
			core_lines_ff <= (pad_in & to_lnk_ff[4:0]) | (dpm_pkg::DBG_PUP & ~to_lnk_ff[4:0]);
	end
	assign core_lines = core_lines_ff;

	// Link-domain debug drive: serial data on A13, test data or trace on B3
	logic tms_out_ff;
	logic tms_oe_ff;
	logic tdo_out_ff;
	logic tdo_oe_ff;
	always_ff @(negedge tck_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tms_out_ff <= 1'b0;
			tms_oe_ff  <= 1'b0;
			tdo_out_ff <= 1'b0;
			tdo_oe_ff  <= 1'b0;
		end
		else
		begin
			// Device drives data only in its return phase; the probe owns it otherwise
			tms_out_ff <= core_in.swd_out;
			tms_oe_ff  <= core_in.swd_oe & to_lnk_ff[dpm_pkg::LINE_TMS_SWD];
			if (to_lnk_ff[5])
			begin
				tdo_out_ff <= core_in.trace;
				tdo_oe_ff  <= to_lnk_ff[dpm_pkg::LINE_TDO];
			end
			else
			begin
				tdo_out_ff <= core_in.tdo;
				tdo_oe_ff  <= core_in.tdo_oe & to_lnk_ff[dpm_pkg::LINE_TDO];
			end
		end
	end

	// Debug drive into system domain as levels, three flops with agreement
	logic [3:0] dbg_s1_ff;
	logic [3:0] dbg_s2_ff;
	logic [3:0] dbg_s3_ff;
	logic [3:0] dbg_ff;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dbg_s1_ff <= 4'h0;
			dbg_s2_ff <= 4'h0;
			dbg_s3_ff <= 4'h0;
			dbg_ff    <= 4'h0;
		end
		else
		begin
			dbg_s1_ff <= {tdo_oe_ff, tdo_out_ff, tms_oe_ff, tms_out_ff};
			dbg_s2_ff <= dbg_s1_ff;
			dbg_s3_ff <= dbg_s2_ff;
			dbg_ff    <= (dbg_s2_ff & dbg_s3_ff) | (dbg_ff & (dbg_s2_ff | dbg_s3_ff));
		end
	end

	// Pad inputs synchronised for software reads, three flops with agreement
	logic [4:0] pin_s1_ff;
	logic [4:0] pin_s2_ff;
	logic [4:0] pin_s3_ff;
	logic [4:0] pin_ff;
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_s1_ff <= 5'h00;
			pin_s2_ff <= 5'h00;
			pin_s3_ff <= 5'h00;
			pin_ff    <= 5'h00;
		end
		else
		begin
			pin_s1_ff <= pad_in;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			pin_ff    <= (pin_s2_ff & pin_s3_ff) | (pin_ff & (pin_s2_ff | pin_s3_ff));
		end
	end
	assign gpio_in = pin_ff;

	// ==============================================================================
	// Pad multiplexer, one slice per line
	// ==============================================================================
	logic [4:0] dbg_out;
	logic [4:0] dbg_oe;
	// Only A13 and B3 are ever driven by debug; clock, data-in and reset stay inputs
	assign dbg_out = {1'b0, dbg_ff[2], 1'b0, 1'b0, dbg_ff[0]};
	assign dbg_oe  = {1'b0, dbg_ff[3], 1'b0, 1'b0, dbg_ff[1]};

	genvar gi;
	generate
		for (gi = 0; gi < dpm_pkg::NUM_LINES; gi++)
		begin : g_line
			// One driver per bit: each slice owns only its own line's controls
			// Claimed lines take debug drive and pulls, released ones the GPIO registers
			assign nxt_pad.out[gi]     = claim[gi] ? dbg_out[gi] : gpio_out_ff[gi];
			assign nxt_pad.oe[gi]      = claim[gi] ? dbg_oe[gi] : gpio_dir_ff[gi];
			assign nxt_pad.pull_up[gi] = claim[gi] ? dpm_pkg::DBG_PUP[gi] : gpio_pup_ff[gi];
			assign nxt_pad.pull_dn[gi] = claim[gi] ? dpm_pkg::DBG_PDN[gi] : gpio_pdn_ff[gi];
		end
	endgenerate

	// Elaboration check: the pad slices and the claim masks assume five lines
	if (dpm_pkg::NUM_LINES != 5)
	begin : g_bad_lines
		$error("debug line count must be five");
	end

	// Registered pad control; reset gives debug ownership with its pulls
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pad_ctl.out     <= 5'h00;
			pad_ctl.oe      <= 5'h00;
			pad_ctl.pull_up <= dpm_pkg::DBG_PUP;
			pad_ctl.pull_dn <= dpm_pkg::DBG_PDN;
		end
		else
			pad_ctl <= nxt_pad;
	end

	// ==============================================================================
	// Register read port
	// ==============================================================================
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (reg_addr == dpm_pkg::ADDR_PORT_CFG)
				reg_rdata <= {5'h00, trace_en_ff, mode_ff};
			else if (reg_addr == dpm_pkg::ADDR_GPIO_OUT)
				reg_rdata <= {3'h0, gpio_out_ff};
			else if (reg_addr == dpm_pkg::ADDR_GPIO_DIR)
				reg_rdata <= {3'h0, gpio_dir_ff};
			else if (reg_addr == dpm_pkg::ADDR_GPIO_PUP)
				reg_rdata <= {3'h0, gpio_pup_ff};
			else if (reg_addr == dpm_pkg::ADDR_GPIO_PDN)
				reg_rdata <= {3'h0, gpio_pdn_ff};
			else if (reg_addr == dpm_pkg::ADDR_PIN_IN)
				reg_rdata <= {3'h0, pin_ff};
			else if (reg_addr == dpm_pkg::ADDR_STATUS)
				reg_rdata <= {3'h0, claim};
			else
				reg_rdata <= 8'h00;  // Unmapped reads zero
		end
		else
			reg_rdata <= 8'h00;
	end

endmodule : dpm_pin_assign // dpm_pin_assign

// ===== logic/dpm_pkg.sv
// Package for the debug port pin assignment block: line indices, modes, register map
package dpm_pkg;

	// Line indices within the five-line debug group
	localparam int unsigned LINE_TMS_SWD  = 0;  // port_a_line_13
	localparam int unsigned LINE_TCK_SWC  = 1;  // port_a_line_14
	localparam int unsigned LINE_TDI      = 2;  // port_a_line_15
	localparam int unsigned LINE_TDO      = 3;  // port_b_line_3
	localparam int unsigned LINE_TRST_N   = 4;  // port_b_line_4
	localparam int unsigned NUM_LINES     = 5;

	// Register map
	localparam logic [3:0] ADDR_PORT_CFG  = 4'h0;  // debug mode and trace enable
	localparam logic [3:0] ADDR_GPIO_OUT  = 4'h1;  // general-purpose output values
	localparam logic [3:0] ADDR_GPIO_DIR  = 4'h2;  // 1 = output
	localparam logic [3:0] ADDR_GPIO_PUP  = 4'h3;  // pull-up enables
	localparam logic [3:0] ADDR_GPIO_PDN  = 4'h4;  // pull-down enables
	localparam logic [3:0] ADDR_PIN_IN    = 4'h5;  // synchronised pin levels
	localparam logic [3:0] ADDR_STATUS    = 4'h6;  // claim mask of held lines

	// Field positions in the configuration register
	localparam int unsigned CFG_MODE_LSB  = 0;
	localparam int unsigned CFG_TRACE_BIT = 2;

	// Reset values of general-purpose controls (released-line defaults)
	localparam logic [4:0] RST_GPIO_OUT   = 5'h00;
	localparam logic [4:0] RST_GPIO_DIR   = 5'h00;
	localparam logic [4:0] RST_GPIO_PUP   = 5'h15;  // trst, tdi, tms pulled up
	localparam logic [4:0] RST_GPIO_PDN   = 5'h02;  // tck pulled down

	// Pulls applied while lines are held by the debug port
	localparam logic [4:0] DBG_PUP        = 5'h15;
	localparam logic [4:0] DBG_PDN        = 5'h02;

	// Debug port modes, with the set of lines each one claims
	typedef enum logic [1:0] {
		DPM_FULL       = 2'b00,
		DPM_NO_TRST    = 2'b01,
		DPM_SWD_ONLY   = 2'b10,
		DPM_DISABLED   = 2'b11
	} dpm_mode_t;

	localparam logic [4:0] CLAIM_FULL     = 5'h1F;
	localparam logic [4:0] CLAIM_NO_TRST  = 5'h0F;
	localparam logic [4:0] CLAIM_SWD_ONLY = 5'h03;
	localparam logic [4:0] CLAIM_NONE     = 5'h00;

	// Pad control for the five lines
	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe;
		logic [4:0] pull_up;
		logic [4:0] pull_dn;
	} dpm_pad_t;

	// Core-side debug port signals
	typedef struct packed {
		logic tdo;       // test data out
		logic tdo_oe;    // jtag shifting data out
		logic swd_out;   // serial-wire data driven by device
		logic swd_oe;    // device owns the data line
		logic trace;     // async trace bit
	} dpm_core_t;

endpackage : dpm_pkg

// ===== tb/dpm_pin_assign_sva.sv
// Assertion checker for the debug port pin assignment block
module dpm_pin_assign_sva
(
	input wire logic              clk,        // System clock
	input wire logic              reset_n,    // Async reset, active low
	input wire logic [3:0]        reg_addr,   // Register address
	input wire logic [7:0]        reg_wdata,  // Write data
	input wire logic              reg_wr,     // Write strobe
	input wire logic              reg_rd,     // Read strobe
	input wire logic [7:0]        reg_rdata,  // Read data
	input wire logic [4:0]        pad_in,     // Pad levels
	input wire dpm_pkg::dpm_pad_t pad_ctl,    // Pad controls
	input wire logic [4:0]        gpio_in     // Filtered levels
);
	// ==========================================
	// Register mirrors
	logic [2:0] cfg_ff;
	logic [4:0] out_ff, dir_ff, pup_ff, pdn_ff, held;
	logic [1:0] age_ff;

	// Shadow of the writable registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			{cfg_ff, out_ff, dir_ff, pup_ff, pdn_ff} <= {13'h0000, dpm_pkg::RST_GPIO_PUP, dpm_pkg::RST_GPIO_PDN};
		else if (reg_wr)
		begin
			case (reg_addr)
				dpm_pkg::ADDR_PORT_CFG: cfg_ff <= reg_wdata[2:0];
				dpm_pkg::ADDR_GPIO_OUT: out_ff <= reg_wdata[4:0];
				dpm_pkg::ADDR_GPIO_DIR: dir_ff <= reg_wdata[4:0];
				dpm_pkg::ADDR_GPIO_PUP: pup_ff <= reg_wdata[4:0];
				dpm_pkg::ADDR_GPIO_PDN: pdn_ff <= reg_wdata[4:0];
				default: ;
			endcase
		end
	end

	// Edges since the last write; pads settle two edges after it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			age_ff <= 2'h2;
		else
			age_ff <= reg_wr ? 2'h0 : (age_ff[1] ? 2'h2 : age_ff + 2'h1);
	end

	assign held = (cfg_ff[1:0] == 2'h0) ? 5'h1F : (cfg_ff[1:0] == 2'h1) ? 5'h0F : (cfg_ff[1:0] == 2'h2) ? 5'h03 : 5'h00;

	// ==========================================
	// Properties
	default clocking dck @(posedge clk); endclocking
	default disable iff (!reset_n);

	held_pulls_a: assert property (
		age_ff == 2'h2 |-> (pad_ctl.pull_up & held) == (dpm_pkg::DBG_PUP & held)
			&& (pad_ctl.pull_dn & held) == (dpm_pkg::DBG_PDN & held)) else $error("pull wrong on held line");
	free_up_a: assert property (
		age_ff == 2'h2 |-> (pad_ctl.pull_up & ~held) == (pup_ff & ~held)) else $error("pull-up wrong on free line");
	free_dn_a: assert property (
		age_ff == 2'h2 |-> (pad_ctl.pull_dn & ~held) == (pdn_ff & ~held)) else $error("pull-down wrong on free line");
	input_only_a: assert property (
		age_ff == 2'h2 |-> (pad_ctl.oe & held & 5'h16) == 5'h00) else $error("held input line driven");
	free_dir_a: assert property (
		age_ff == 2'h2 |-> (pad_ctl.oe & ~held) == (dir_ff & ~held)) else $error("free line direction wrong");
	free_out_a: assert property (
		age_ff == 2'h2 |-> (pad_ctl.out & ~held) == (out_ff & ~held)) else $error("free line output wrong");
	idle_rdata_a: assert property (
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read cycle");
	unmapped_rd_a: assert property (
		reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
	pin_filter_a: assert property (
		$stable(pad_in) [*8] |-> gpio_in == pad_in) else $error("filtered level stale");
endmodule // dpm_pin_assign_sva

bind dpm_pin_assign dpm_pin_assign_sva sva_u (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .pad_in, .pad_ctl, .gpio_in);

// ===== tb/dpm_probe_model.sv
// Debug probe model: drives the test clock and the shared lines from the far side
module dpm_probe_model
(
	input  wire logic              run,      // Clock runs within a frame
	input  wire logic [4:0]        drv_en,   // Lines the probe drives
	input  wire logic [4:0]        drv_val,  // Levels it drives
	input  wire dpm_pkg::dpm_pad_t pad_ctl,  // Device pad controls
	output logic                   tck_clk,  // Test clock
	output logic [4:0]             pad_in    // Resolved line levels
);
	timeunit 1ns;
	timeprecision 1ns;
	logic flt;

	// ==========================================
	// Test clock, phase unrelated to the system clock, still outside frames
	initial
	begin
		tck_clk = 1'b0;
		flt = 1'b0;
		#7;
		forever
		begin
			#16;
			tck_clk <= run ? ~tck_clk : 1'b0;
			flt <= ~flt; // Unpulled undriven lines wander
		end
	end

	// ==========================================
	// Line resolution: device drive first, then probe, then pulls
	always_comb
	begin
		for (int i = 0; i < 5; i++)
		begin
			if (pad_ctl.oe[i])
				pad_in[i] = pad_ctl.out[i];
			else if (drv_en[i])
				pad_in[i] = (i == 1) ? tck_clk : drv_val[i];
			else
				pad_in[i] = pad_ctl.pull_up[i] | (~pad_ctl.pull_dn[i] & flt);
		end
	end
endmodule // dpm_probe_model

// ===== tb/dpm_pin_assign_tb.sv
// Testbench for the debug port pin assignment block
module dpm_pin_assign_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic               clk, reset_n, reg_wr, reg_rd, run, tck_clk;
	logic [3:0]         reg_addr;
	logic [7:0]         reg_wdata, reg_rdata, d;
	logic [4:0]         pad_in, core_lines, gpio_in, cl, ox;
	dpm_pkg::dpm_pad_t  pad_ctl;
	dpm_pkg::dpm_core_t core_in;
	int                 mismatches, checks;
	logic [4:0]         claim_tab [4] = '{5'h1F, 5'h0F, 5'h03, 5'h00};
	logic [7:0]         rst_tab [5] = '{8'h00, 8'h00, 8'h00, 8'h15, 8'h02};

	dpm_pin_assign dut_u (.clk, .reset_n, .tck_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.pad_in, .pad_ctl, .core_in, .core_lines, .gpio_in);
	dpm_probe_model probe_u (.run, .drv_en(5'h16), .drv_val(5'h04), .pad_ctl, .tck_clk, .pad_in);

	always #25 clk = ~clk;

	// ==========================================
	// Access and compare tasks
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_pad(input string n, input logic [4:0] e, input logic [4:0] g);
		checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	// One probe frame, then the link clock stands still
	task automatic frame;
		run <= 1'b1;
		repeat (30) @(posedge clk);
		run <= 1'b0;
		repeat (12) @(posedge clk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		{clk, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, core_in} = '0;
		run = 1'b1;
		repeat (5) @(posedge clk);
		chk_pad("reset pull-up", 5'h15, pad_ctl.pull_up);
		chk_pad("reset core lines", 5'h15, core_lines);
		reset_n <= 1'b1;
		rd(dpm_pkg::ADDR_STATUS);
		chk_reg("claim", 8'h1F, {3'h0, d[4:0]});
		for (int a = 0; a < 5; a++)
		begin
			rd(a[3:0]);
			chk_reg("reset value", rst_tab[a], d);
		end
		wr(4'hE, 8'hFF);
		rd(4'hE);
		chk_reg("unmapped", 8'h00, d);
		wr(dpm_pkg::ADDR_GPIO_OUT, 8'h05);
		wr(dpm_pkg::ADDR_GPIO_DIR, 8'h1E);
		wr(dpm_pkg::ADDR_GPIO_PUP, 8'h0A);
		wr(dpm_pkg::ADDR_GPIO_PDN, 8'h11);
		rd(dpm_pkg::ADDR_GPIO_PUP);
		chk_reg("pull-up reg", 8'h0A, d);
		core_in <= 5'b11010; // Data out high and driven, serial data driven low
		for (int m = 1; m < 5; m++)
		begin
			wr(dpm_pkg::ADDR_PORT_CFG, {6'h00, m[1:0]});
			frame();
			cl = claim_tab[m[1:0]];
			ox = (cl & 5'h09) | (~cl & 5'h1E);
			rd(dpm_pkg::ADDR_STATUS);
			chk_reg("claim", {3'h0, cl}, {3'h0, d[4:0]});
			chk_pad("oe", ox, pad_ctl.oe);
			chk_pad("out", ((cl & 5'h08) | (~cl & 5'h05)) & ox, pad_ctl.out & ox);
			chk_pad("pull-down", (cl & 5'h02) | (~cl & 5'h11), pad_ctl.pull_dn);
			chk_pad("free core lines", 5'h15 & ~cl, core_lines & ~cl);
			chk_pad("held core lines", 5'h04 & cl & 5'h14, core_lines & cl & 5'h14);
			chk_pad("gpio_in", 5'h05 & ~cl & 5'h1E, gpio_in & ~cl & 5'h1E);
		end
		core_in <= 5'b10001; // Data out not driven, trace bit high
		wr(dpm_pkg::ADDR_PORT_CFG, 8'h00);
		frame();
		chk_pad("trace off", 5'h00, pad_ctl.oe & 5'h09);
		wr(dpm_pkg::ADDR_PORT_CFG, 8'h04);
		frame();
		chk_pad("trace on", 5'h08, pad_ctl.oe & pad_ctl.out & 5'h08);
		run <= 1'b1;
		reset_n <= 1'b0;
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rd(dpm_pkg::ADDR_GPIO_DIR);
		chk_reg("dir after reset", 8'h00, d);
		rd(dpm_pkg::ADDR_STATUS);
		chk_reg("claim after reset", 8'h1F, {3'h0, d[4:0]});
		close_out();
	end

	// Watchdog well beyond the expected run of about 16 us
	initial
	begin
		#200us;
		mismatches++;
		close_out();
	end
endmodule // dpm_pin_assign_tb
